// ===== verilog/pdfc_pkg.sv
// Shared constants, field layout and decode helpers of the frequency control block
`default_nettype none

package pdfc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Frequency control register layout
	localparam logic [15:0] FREQ_RESET = 16'h0102;     // Value loaded by power-on reset
	localparam logic [15:0] FREQ_RW_MASK = 16'he03f;   // Bits software may change
	localparam logic [15:0] FREQ_FIXED_ONE = 16'h0100; // Bit that always reads as one
	localparam int MULT_HI_BIT = 15;                   // Multiplier select, high bit
	localparam int MULT_MID_BIT = 5;                   // Multiplier select, middle bit
	localparam int MULT_LO_BIT = 4;                    // Multiplier select, low bit
	localparam int CORE_HI_BIT = 14;                   // Core divider select, high bit
	localparam int CORE_MID_BIT = 3;                   // Core divider select, middle bit
	localparam int CORE_LO_BIT = 2;                    // Core divider select, low bit
	localparam int PER_HI_BIT = 13;                    // Peripheral divider select, high bit
	localparam int PER_MID_BIT = 1;                    // Peripheral divider select, middle bit
	localparam int PER_LO_BIT = 0;                     // Peripheral divider select, low bit

	////////////////////////////////////////////////////////////////////////////////
	// Select codes, shared by multiplier and both dividers
	localparam logic [2:0] CODE_X1 = 3'h0; // x1 or divide by 1
	localparam logic [2:0] CODE_X2 = 3'h1; // x2 or divide by 2
	localparam logic [2:0] CODE_X3 = 3'h4; // x3 or divide by 3
	localparam logic [2:0] CODE_X4 = 3'h2; // x4 or divide by 4
	localparam logic [2:0] CODE_X6 = 3'h5; // x6 or divide by 6
	localparam logic [2:0] FACT_0 = 3'h0;  // Second loop switched off
	localparam logic [2:0] FACT_1 = 3'h1;  // Factor one
	localparam logic [2:0] FACT_2 = 3'h2;  // Factor two
	localparam logic [2:0] FACT_3 = 3'h3;  // Factor three
	localparam logic [2:0] FACT_4 = 3'h4;  // Factor four
	localparam logic [2:0] FACT_6 = 3'h6;  // Factor six

	////////////////////////////////////////////////////////////////////////////////
	// Clock mode pins
	localparam logic [2:0] MODE_0 = 3'h0; // Second loop at x1
	localparam logic [2:0] MODE_1 = 3'h1; // External clock, second loop x4
	localparam logic [2:0] MODE_2 = 3'h2; // Crystal, second loop x4
	localparam logic [2:0] MODE_7 = 3'h7; // Second loop off

	////////////////////////////////////////////////////////////////////////////////
	// Controller register map and fields
	localparam logic [2:0] HOST_FREQ_WR = 3'h0; // Write: send value to the device
	localparam logic [2:0] HOST_FREQ_RD = 3'h1; // Read: device register
	localparam logic [2:0] HOST_CNT = 3'h2;     // Settle counter value
	localparam logic [2:0] HOST_CTRL = 3'h3;    // Count run bit and prescale select
	localparam logic [2:0] HOST_STATUS = 3'h4;  // Halt, settle, reject, counter
	localparam int CTRL_RUN_BIT = 7;            // Count run bit position
	localparam int STAT_HALT_BIT = 0;           // Processor halted
	localparam int STAT_SETTLE_BIT = 1;         // Settle count requested
	localparam int STAT_REJECT_BIT = 2;         // Last frequency write refused
	localparam logic [7:0] CNT_MAX = 8'hff;     // Counter value that overflows next

	////////////////////////////////////////////////////////////////////////////////
	// Values software may place in the register
	localparam int LEGAL_COUNT = 15;
	localparam logic [15:0] LEGAL_TABLE [LEGAL_COUNT] = '{
		16'h0100, 16'h0101, 16'h0102, 16'h0111, 16'h0112, 16'h0115, 16'h0116, 16'h0122,
		16'h0126, 16'h012a, 16'ha100, 16'ha101, 16'he100, 16'he101, 16'ha111};

	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers
	function automatic logic [2:0] field_mult(input logic [15:0] v);
		return {v[MULT_HI_BIT], v[MULT_MID_BIT], v[MULT_LO_BIT]};
	endfunction

	function automatic logic [2:0] field_core(input logic [15:0] v);
		return {v[CORE_HI_BIT], v[CORE_MID_BIT], v[CORE_LO_BIT]};
	endfunction

	function automatic logic [2:0] field_per(input logic [15:0] v);
		return {v[PER_HI_BIT], v[PER_MID_BIT], v[PER_LO_BIT]};
	endfunction

	// Code to factor; reserved codes fall back to one
	function automatic logic [2:0] code_factor(input logic [2:0] c);
		case (c)
			CODE_X2: return FACT_2;
			CODE_X3: return FACT_3;
			CODE_X4: return FACT_4;
			CODE_X6: return FACT_6;
			default: return FACT_1;
		endcase
	endfunction

	// Mode pins to second loop factor
	function automatic logic [2:0] pll2_factor(input logic [2:0] m);
		case (m)
			MODE_0: return FACT_1;
			MODE_1, MODE_2: return FACT_4;
			default: return FACT_0;
		endcase
	endfunction

	// Prescale select to mask: divide by 1,4,16,32,64,256,1024,4096
	function automatic logic [11:0] presc_mask(input logic [2:0] sel);
		case (sel)
			3'h0: return 12'h000;
			3'h1: return 12'h003;
			3'h2: return 12'h00f;
			3'h3: return 12'h01f;
			3'h4: return 12'h03f;
			3'h5: return 12'h0ff;
			3'h6: return 12'h3ff;
			default: return 12'hfff;
		endcase
	endfunction

	function automatic logic is_legal(input logic [15:0] v);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < LEGAL_COUNT; i++) begin
			if (LEGAL_TABLE[i] == v) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

endpackage

`default_nettype wire

// ===== verilog/pdfc_if.sv
// Interface joining the frequency control block and its controlling party
`default_nettype none

interface pdfc_if;
	logic wr;                // Register write strobe, one cycle
	logic rd;                // Register read strobe, one cycle
	logic word;              // Access is a full 16-bit word
	logic [15:0] wdata;      // Write data
	logic [15:0] rdata;      // Read data, same cycle as rd
	logic overflow;          // Settle counter overflow pulse
	logic settle_req;        // Device asks the settle counter to run
	logic halt;              // Processor held
	logic core_en;           // Core clock enable pulse
	logic periph_en;         // Peripheral clock enable pulse
	logic count_clk_en;      // Peripheral clock kept for the settle counter
	logic [2:0] pll1_mult;   // Active first loop factor
	logic [2:0] pll2_mult;   // Second loop factor from mode pins
	logic [2:0] core_div;    // Active core divide factor
	logic [2:0] periph_div;  // Active peripheral divide factor

	// Frequency control end
	modport dev (
		input wr, rd, word, wdata, overflow,
		output rdata, settle_req, halt, core_en, periph_en, count_clk_en,
		output pll1_mult, pll2_mult, core_div, periph_div
	);

	// Controlling end: processor access and settle counter
	modport host (
		output wr, rd, word, wdata, overflow,
		input rdata, settle_req, halt, core_en, periph_en, count_clk_en,
		input pll1_mult, pll2_mult, core_div, periph_div
	);
endinterface

`default_nettype wire

// ===== verilog/pdfc_dev.sv
// Frequency control end: register, clock dividers and settle sequencing
//
// The address map and strobed register access were chosen for this implementation.
`default_nettype none

module pdfc_dev
	import pdfc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [2:0] i_clk_mode,
	pdfc_if.dev bus,
	output logic [15:0] o_freq,
	output logic o_settling
);
	import pdfc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State

	// Running normally or waiting for the loop to settle
	typedef enum logic {
		PH_RUN,
		PH_SETTLE
	} pdfc_phase_t;

	// Whole state of the block
	typedef struct packed {
		pdfc_phase_t phase;  // Sequencing phase
		logic [15:0] freq;   // Frequency control register as read
		logic [2:0] act_mult;  // Multiplier code in use
		logic [2:0] act_core;  // Core divider code in use
		logic [2:0] act_per;   // Peripheral divider code in use
		logic [2:0] core_cnt;  // Core divider counter
		logic [2:0] per_cnt;   // Peripheral divider counter
		logic [2:0] mode_s1;   // Mode pin synchroniser, first stage
		logic [2:0] mode_s2;   // Mode pin synchroniser, second stage
		logic [2:0] mode_s3;   // Mode pin synchroniser, third stage
		logic [2:0] mode;      // Accepted clock mode
	} pdfc_dev_state_t;

	// Power-on values; field codes match the register reset value
	localparam pdfc_dev_state_t ST_RESET = '{
		phase: PH_RUN,
		freq: FREQ_RESET,
		act_mult: CODE_X1,
		act_core: CODE_X1,
		act_per: CODE_X4,
		mode: MODE_0,
		default: '0
	};

	pdfc_dev_state_t s;       // Registered state
	pdfc_dev_state_t next_s;  // Next state
	logic [15:0] wr_val;      // Written value with fixed bits forced
	logic wr_ok;              // Word write accepted
	logic [2:0] core_fact;    // Core divide factor in use
	logic [2:0] per_fact;     // Peripheral divide factor in use

	////////////////////////////////////////////////////////////////////////////////
	// Decode of the fields in use

	// Factors of the active codes
	always_comb begin
		core_fact = code_factor(s.act_core);
		per_fact = code_factor(s.act_per);
	end

	// Write value: only writable bits kept, reserved zero, bit eight one
	always_comb begin
		wr_val = (bus.wdata & FREQ_RW_MASK) | FREQ_FIXED_ONE;
		wr_ok = bus.wr && bus.word;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_s = s;

		// Mode pins pass three flops; accept once stages two and three agree
		next_s.mode_s1 = i_clk_mode;
		next_s.mode_s2 = s.mode_s1;
		next_s.mode_s3 = s.mode_s2;
		if (s.mode_s2 == s.mode_s3) begin
			next_s.mode = s.mode_s3;
		end

		unique case (s.phase)
			// Normal running: take writes
			PH_RUN: begin
				if (wr_ok) begin
					next_s.freq = wr_val;
					if (field_mult(wr_val) != s.act_mult) begin
						// New multiplier: hold the core and peripheral clocks until the loop settles
						next_s.phase = PH_SETTLE;
					end else begin
						// Dividers only: no settle count, use them now
						next_s.act_core = field_core(wr_val);
						next_s.act_per = field_per(wr_val);
					end
				end
			end
			// Settling: processor is halted, so writes cannot arrive
			PH_SETTLE: begin
				if (bus.overflow) begin
					// Overflow ends the wait and releases the new clocks
					next_s.act_mult = field_mult(s.freq);
					next_s.act_core = field_core(s.freq);
					next_s.act_per = field_per(s.freq);
					next_s.phase = PH_RUN;
				end
			end
		endcase

		// Core divider; held in reset while settling so it restarts cleanly
		if (s.phase == PH_SETTLE || s.core_cnt >= core_fact - FACT_1) begin
			next_s.core_cnt = '0;
		end else begin
			next_s.core_cnt = s.core_cnt + 3'h1;
		end

		// Peripheral divider keeps running: the settle counter needs it
		if (s.per_cnt >= per_fact - FACT_1) begin
			next_s.per_cnt = '0;
		end else begin
			next_s.per_cnt = s.per_cnt + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register; only power-on reset touches the contents

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s <= ST_RESET;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Clock enables; i_clk stands for the first loop output
	always_comb begin
		bus.core_en = (s.phase == PH_RUN) && (s.core_cnt == 3'h0);
		bus.periph_en = (s.phase == PH_RUN) && (s.per_cnt == 3'h0);
		bus.count_clk_en = (s.per_cnt == 3'h0);
	end

	// Ratios in use and sequencing status
	always_comb begin
		bus.pll1_mult = code_factor(s.act_mult);
		bus.pll2_mult = pll2_factor(s.mode);
		bus.core_div = core_fact;
		bus.periph_div = per_fact;
		bus.halt = (s.phase == PH_SETTLE);
		bus.settle_req = (s.phase == PH_SETTLE);
	end

	// Register read; narrower accesses read zero
	always_comb begin
		if (bus.rd && bus.word) begin
			bus.rdata = s.freq;
		end else begin
			bus.rdata = '0;
		end
	end

	// User-side view
	always_comb begin
		o_freq = s.freq;
		o_settling = (s.phase == PH_SETTLE);
	end

endmodule

`default_nettype wire

// ===== verilog/pdfc_host.sv
// Controlling end: register port, write checks and the settle counter
`default_nettype none

module pdfc_host
	import pdfc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [2:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_dma_active,
	output logic [15:0] o_rdata,
	pdfc_if.host bus
);
	import pdfc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [15:0] rdata;   // Read data for the cycle after a read
		logic wr_pend;        // Write strobe toward the device
		logic [15:0] wdata;   // Write data toward the device
		logic [15:0] shadow;  // Last value sent to the device
		logic [7:0] cnt;      // Settle counter
		logic run;            // Count run bit
		logic [2:0] presc;    // Count prescale select
		logic [11:0] pre_cnt; // Prescaler
		logic reject;         // Last frequency write refused
		logic ovf;            // Overflow pulse
	} pdfc_host_state_t;

	localparam pdfc_host_state_t HS_RESET = '{shadow: FREQ_RESET, default: '0};

	pdfc_host_state_t s;       // Registered state
	pdfc_host_state_t next_s;  // Next state
	logic counting;            // Counter allowed to advance
	logic tick;                // Prescaled count pulse
	logic mult_change;         // Write changes the multiplier
	logic dma_block;           // Write unsafe during a transfer
	logic accept;              // Frequency write may go out

	////////////////////////////////////////////////////////////////////////////////
	// Write checks

	always_comb begin
		mult_change = field_mult(i_wdata) != field_mult(s.shadow);
		// Divider change, same multiplier, core not equal to bus rate
		dma_block = i_dma_active && !mult_change &&
			(field_core(i_wdata) != field_core(s.shadow)) &&
			(code_factor(field_mult(i_wdata)) != code_factor(field_core(i_wdata)));
		accept = is_legal(i_wdata) && !dma_block && !bus.halt &&
			!(mult_change && s.run);
	end

	// Prescaled tick from the kept peripheral clock
	always_comb begin
		// The overflow pulse ends the settle count; no step while the device restarts
		counting = (bus.settle_req && !s.ovf) || s.run;
		tick = bus.count_clk_en && ((s.pre_cnt & presc_mask(s.presc)) == presc_mask(s.presc));
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		next_s = s;
		next_s.wr_pend = 1'b0;
		next_s.ovf = 1'b0;
		next_s.rdata = '0;

		// Settle counter
		if (counting && bus.count_clk_en) begin
			next_s.pre_cnt = s.pre_cnt + 12'h001;
		end
		if (counting && tick) begin
			next_s.cnt = s.cnt + 8'h01;
			if (s.cnt == CNT_MAX) begin
				next_s.ovf = 1'b1;
			end
		end

		// Register writes; a software load wins over a count step
		if (i_wr) begin
			unique case (i_addr)
				HOST_FREQ_WR: begin
					if (accept) begin
						next_s.wr_pend = 1'b1;
						next_s.wdata = i_wdata;
						next_s.shadow = (i_wdata & FREQ_RW_MASK) | FREQ_FIXED_ONE;
						next_s.reject = 1'b0;
					end else begin
						next_s.reject = 1'b1;
					end
				end
				HOST_CNT: begin
					next_s.cnt = i_wdata[7:0];
					next_s.pre_cnt = '0;
				end
				HOST_CTRL: begin
					next_s.run = i_wdata[CTRL_RUN_BIT];
					next_s.presc = i_wdata[2:0];
				end
				default: begin
				end
			endcase
		end

		// Register reads
		if (i_rd) begin
			unique case (i_addr)
				HOST_FREQ_RD: next_s.rdata = bus.rdata;
				HOST_CNT: next_s.rdata = {8'h00, s.cnt};
				HOST_CTRL: next_s.rdata = {8'h00, s.run, 4'h0, s.presc};
				HOST_STATUS: next_s.rdata = {s.cnt, 5'h00, s.reject, bus.settle_req, bus.halt};
				default: next_s.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s <= HS_RESET;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	always_comb begin
		bus.wr = s.wr_pend;
		bus.wdata = s.wdata;
		bus.word = 1'b1;
		bus.rd = i_rd && (i_addr == HOST_FREQ_RD);
		bus.overflow = s.ovf;
		o_rdata = s.rdata;
	end

endmodule

`default_nettype wire

// ===== testbench/pdfc_asserts.sv
// Checker on the link between the frequency control end and its host
`default_nettype none

module pdfc_asserts (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic wr,
	input wire logic rd,
	input wire logic word,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic overflow,
	input wire logic settle_req,
	input wire logic halt,
	input wire logic core_en,
	input wire logic periph_en,
	input wire logic count_clk_en,
	input wire logic [2:0] pll1_mult,
	input wire logic [2:0] core_div,
	input wire logic [2:0] periph_div
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	////////////////////////////////////////////////////////////////////////////////
	// Own decode of a select code into its factor
	function automatic logic [2:0] fac(input logic [2:0] c);
		case (c)
			3'h1: return 3'h2;
			3'h4: return 3'h3;
			3'h2: return 3'h4;
			3'h5: return 3'h6;
			default: return 3'h1;
		endcase
	endfunction

	logic take; // Write that the device accepts
	logic [2:0] m_new; // Multiplier factor carried by the write
	logic [2:0] c_new; // Core divide factor carried by the write
	logic [2:0] p_new; // Peripheral divide factor carried by the write
	logic [2:0] want_mult; // Multiplier waiting for the settle count
	assign take = wr && word && !halt;
	assign m_new = fac({wdata[15], wdata[5], wdata[4]});
	assign c_new = fac({wdata[14], wdata[3], wdata[2]});
	assign p_new = fac({wdata[13], wdata[1], wdata[0]});

	// Remember the multiplier of the last accepted write
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			want_mult <= 3'h1;
		end else if (take) begin
			want_mult <= m_new;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Properties
	property p_quiet;
		halt |-> !core_en && !periph_en && settle_req;
	endproperty
	a_quiet: assert property (p_quiet) else $error("clocks run while halted");

	property p_tick;
		halt |-> ##[0:5] count_clk_en;
	endproperty
	a_tick: assert property (p_tick) else $error("count clock stopped");

	property p_start;
		take && m_new != pll1_mult |=> halt;
	endproperty
	a_start: assert property (p_start) else $error("no halt on new mult");

	property p_hold;
		halt && !overflow |=> halt;
	endproperty
	a_hold: assert property (p_hold) else $error("halt ended early");

	property p_resume;
		halt && overflow |=> !halt && core_en && pll1_mult == want_mult;
	endproperty
	a_resume: assert property (p_resume) else $error("bad resume");

	property p_frozen;
		halt |-> $stable(pll1_mult) && $stable(core_div) && $stable(periph_div);
	endproperty
	a_frozen: assert property (p_frozen) else $error("factors moved");

	property p_div;
		take && m_new == pll1_mult |=> !halt && core_div == $past(c_new)
			&& periph_div == $past(p_new);
	endproperty
	a_div: assert property (p_div) else $error("divider late");

	property p_fixed;
		rd && word |-> rdata[8] && (rdata & 16'h1ec0) == 16'h0000;
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed bits wrong");

	property p_idle;
		!(rd && word) |-> rdata == 16'h0000;
	endproperty
	a_idle: assert property (p_idle) else $error("read data idle");

	// Main scenarios
	c_mult: cover property (take && m_new != pll1_mult);
	c_ovf: cover property (halt && overflow);
	c_div: cover property (take && m_new == pll1_mult);
	c_read: cover property (rd && word);
endmodule

`default_nettype wire

// ===== testbench/pll_divider_frequency_control_bench.sv
// Self-checking bench for the frequency control pair
`default_nettype none

module pll_divider_frequency_control_bench import pdfc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {logic [15:0] v; logic [2:0] m; logic [2:0] c; logic [2:0] p;} pdfc_row_t;
	// Value written, then multiplier, core and peripheral factors
	pdfc_row_t rows [15] = '{
		'{16'h0100, 1, 1, 1}, '{16'h0101, 1, 1, 2}, '{16'h0102, 1, 1, 4},
		'{16'h0111, 2, 1, 2}, '{16'h0112, 2, 1, 4}, '{16'h0115, 2, 2, 2},
		'{16'h0116, 2, 2, 4}, '{16'h0122, 4, 1, 4}, '{16'h0126, 4, 2, 4},
		'{16'h012a, 4, 4, 4}, '{16'ha100, 3, 1, 3}, '{16'ha101, 3, 1, 6},
		'{16'he100, 3, 3, 3}, '{16'he101, 3, 3, 6}, '{16'ha111, 6, 1, 6}};
	logic [2:0] modes [4] = '{3'h0, 3'h1, 3'h2, 3'h7}; // Mode pin codes
	logic [2:0] pll2s [4] = '{3'h1, 3'h4, 3'h4, 3'h0}; // Second loop factors
	logic clk, rstn, wr, rd, dma, settling;
	logic [2:0] addr, mode, pm;
	logic [15:0] wdata, rdata, freq;
	int errors, comparisons;

	pdfc_if pdfc_if_i ();
	pdfc_dev pdfc_dev_i (.i_clk(clk), .i_rstn(rstn), .i_clk_mode(mode), .bus(pdfc_if_i.dev),
		.o_freq(freq), .o_settling(settling));
	pdfc_host pdfc_host_i (.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .i_dma_active(dma), .o_rdata(rdata), .bus(pdfc_if_i.host));
	pdfc_asserts pdfc_asserts_i (.i_clk(clk), .i_rstn(rstn), .wr(pdfc_if_i.wr),
		.rd(pdfc_if_i.rd), .word(pdfc_if_i.word), .wdata(pdfc_if_i.wdata),
		.rdata(pdfc_if_i.rdata), .overflow(pdfc_if_i.overflow),
		.settle_req(pdfc_if_i.settle_req), .halt(pdfc_if_i.halt), .core_en(pdfc_if_i.core_en),
		.periph_en(pdfc_if_i.periph_en), .count_clk_en(pdfc_if_i.count_clk_en),
		.pll1_mult(pdfc_if_i.pll1_mult), .core_div(pdfc_if_i.core_div),
		.periph_div(pdfc_if_i.periph_div));

	////////////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One-cycle write, then one idle edge so the device has taken it
	task automatic put(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	// One-cycle read, data looked at in the cycle after
	task automatic get(input logic [2:0] a, input logic [15:0] exp, input logic [15:0] msk);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata & msk, exp);
	endtask

	// Wait, bounded, for the settle count to release the core
	task automatic settle();
		int n;
		n = 0;
		while (pdfc_if_i.halt !== 1'b0 && n < 4000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 4000) begin
			errors++;
		end
	endtask

	// Count enable pulses over twelve cycles, a common multiple of every divide factor
	task automatic rate(input logic [2:0] c, input logic [2:0] p);
		int nc;
		int np;
		int nk;
		nc = 0;
		np = 0;
		nk = 0;
		repeat (12) begin
			@(posedge clk);
			#1;
			if (pdfc_if_i.core_en === 1'b1) begin
				nc++;
			end
			if (pdfc_if_i.periph_en === 1'b1) begin
				np++;
			end
			if (pdfc_if_i.count_clk_en === 1'b1) begin
				nk++;
			end
		end
		chk(16'(nc), 16'(12 / c));
		chk(16'(np), 16'(12 / p));
		chk(16'(nk), 16'(12 / p));
	endtask

	task automatic check_reset();
		chk(freq, 16'h0102);
		chk(16'(pdfc_if_i.pll1_mult), 16'h1);
		chk(16'(pdfc_if_i.core_div), 16'h1);
		chk(16'(pdfc_if_i.periph_div), 16'h4);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#200000;
		errors++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rstn, wr, rd, dma, addr, mode, wdata} = '0;
		errors = 0;
		comparisons = 0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		check_reset();
		get(HOST_FREQ_RD, 16'h0102, 16'hffff);
		pm = 3'h1;
		// Every permitted value, settling where the multiplier moves
		foreach (rows[i]) begin
			put(HOST_CNT, 16'h00fe);
			put(HOST_FREQ_WR, rows[i].v);
			chk(16'(pdfc_if_i.halt), 16'(rows[i].m != pm));
			chk(16'(settling), 16'(rows[i].m != pm));
			settle();
			chk(16'(pdfc_if_i.pll1_mult), 16'(rows[i].m));
			chk(16'(pdfc_if_i.core_div), 16'(rows[i].c));
			chk(16'(pdfc_if_i.periph_div), 16'(rows[i].p));
			rate(rows[i].c, rows[i].p);
			get(HOST_FREQ_RD, rows[i].v, 16'hffff);
			pm = rows[i].m;
		end
		// Value outside the permitted set is refused
		put(HOST_FREQ_WR, 16'hffff);
		get(HOST_STATUS, 16'h0004, 16'h0007);
		get(HOST_FREQ_RD, 16'ha111, 16'hffff);
		// Core divider change under a transfer, ratio not one to one
		put(HOST_CNT, 16'h00fe);
		put(HOST_FREQ_WR, 16'h0115);
		settle();
		@(posedge clk);
		dma <= 1'b1;
		put(HOST_FREQ_WR, 16'h0111);
		get(HOST_STATUS, 16'h0004, 16'h0007);
		@(posedge clk);
		dma <= 1'b0;
		put(HOST_FREQ_WR, 16'h0111);
		chk(16'(pdfc_if_i.halt), 16'h0);
		get(HOST_STATUS, 16'h0000, 16'h0007);
		// Multiplier change with the counter still running
		put(HOST_CTRL, 16'h0080);
		put(HOST_FREQ_WR, 16'h0122);
		get(HOST_STATUS, 16'h0004, 16'h0007);
		// Run bit off, count on every fourth kept peripheral pulse
		put(HOST_CTRL, 16'h0001);
		get(HOST_CTRL, 16'h0001, 16'hffff);
		// Long settle; a write meanwhile is refused
		put(HOST_CNT, 16'h0080);
		put(HOST_FREQ_WR, 16'h0122);
		get(HOST_STATUS, 16'h0003, 16'h0007);
		put(HOST_FREQ_WR, 16'h0100);
		get(HOST_STATUS, 16'h0007, 16'h0007);
		settle();
		chk(16'(pdfc_if_i.pll1_mult), 16'h4);
		chk(freq, 16'h0122);
		get(HOST_CNT, 16'h0000, 16'hffff);
		// Unmapped places
		get(3'h6, 16'h0000, 16'hffff);
		put(3'h5, 16'h0101);
		get(HOST_FREQ_RD, 16'h0122, 16'hffff);
		// Mode pins set the second loop
		foreach (modes[i]) begin
			@(posedge clk);
			mode <= modes[i];
			repeat (6) @(posedge clk);
			#1;
			chk(16'(pdfc_if_i.pll2_mult), 16'(pll2s[i]));
		end
		// Reset in mid-run restores the initial value
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1;
		check_reset();
		report_and_stop();
	end
endmodule

`default_nettype wire
